// ===== smts_pkg.sv
// Shared constants and types for the multibuffered serial port trigger
// and buffer memory block.
// Assumes a 40 MHz interface clock and a separate serial link clock.
package smts_pkg;

  // Buffer memory shape: 128 entries of four 16-bit fields.
  localparam int NUM_ENTRIES = 128;
  localparam int IDX_W       = 7;
  localparam int FIELD_W     = 16;
  localparam int NUM_FIELDS  = 4;
  localparam int FLD_SEL_W   = 2;

  // Field codes within one buffer entry.
  localparam logic [1:0] FLD_TX   = 2'h0;
  localparam logic [1:0] FLD_RX   = 2'h1;
  localparam logic [1:0] FLD_CTRL = 2'h2;
  localparam logic [1:0] FLD_STAT = 2'h3;

  // Trigger select codes: zero disables, then port pins, timer, tick.
  localparam int         SEL_W          = 4;
  localparam int         NUM_SRC        = 16;
  localparam logic [3:0] SEL_NONE       = 4'h0;
  localparam int         SRC_PORT_FIRST = 1;
  localparam int         PORT_NUM       = 8;
  localparam int         SRC_TMR_FIRST  = 9;
  localparam int         TMR_NUM        = 6;
  localparam int         TMR_CH_FIRST   = 8;
  localparam int         TMR_CH_STEP    = 2;
  localparam int         TMR_CH_W       = 19;
  localparam int         SRC_TICK       = 15;
  localparam int         EXT_NUM        = 14;

  // Internal tick period and its length in interface clock cycles.
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W         = 16;

  // Trigger event types selectable per transfer group.
  typedef enum logic [1:0] {
    EVT_RISE = 2'b00,
    EVT_FALL = 2'b01,
    EVT_LOW  = 2'b10,
    EVT_HIGH = 2'b11
  } smts_evt_e;

  // Transfer group sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01
  } smts_seq_e;

endpackage : smts_pkg

// ===== smts_core.sv
// Buffer memory, transfer group trigger selection and the word path from
// the buffer memory toward the serial shift engine on the link clock.
// Assumes trigger pins and timer outputs are asynchronous to clk, and
// that the shift engine consumes words with valid and ready on link_clk.
`timescale 1ns/10ps

// What this block does
// - 128 entries, each four 16-bit fields.
// - Groups span configurable consecutive buffer entries.
// - Each group has own source and event.
// - Events include rising edge and held low.
// - Fifteen sources, usable by any group.
// - Decode 4-bit select into pins, timer, tick.
// - Timer triggers taken from internal channel outputs.
// - Port triggers taken after the input buffer.
module smts_core #(
  parameter int NUM_GROUPS = 8,                    // Transfer groups.
  parameter int FIFO_DEPTH = 2,                    // Word buffer entries.
  parameter int TICK_CYCLES = smts_pkg::TICK_CYCLES // Tick period, cycles.
) (
  input  wire logic clk,                                  // Interface clock.
  input  wire logic rst_b,                                // Sync reset, low.
  input  wire logic link_clk,                             // Link clock.
  input  wire logic [smts_pkg::PORT_NUM-1:0] port_a_pins, // Pad inputs.
  input  wire logic [smts_pkg::TMR_CH_W-1:0]
                    timer_coprocessor_channels,           // Timer outputs.
  input  wire logic [NUM_GROUPS-1:0] grp_enable,          // Group enables.
  input  wire logic [NUM_GROUPS*smts_pkg::SEL_W-1:0]
                    group_trigger_select,                 // Source codes.
  input  wire logic [NUM_GROUPS*2-1:0] grp_trig_evt,      // Event types.
  input  wire logic [NUM_GROUPS*smts_pkg::IDX_W-1:0]
                    grp_start_idx,                        // First entries.
  input  wire logic [NUM_GROUPS*smts_pkg::IDX_W-1:0]
                    grp_end_idx,                          // Last entries.
  input  wire logic mem_wr_en,                            // Write strobe.
  input  wire logic [smts_pkg::IDX_W-1:0] mem_wr_idx,     // Write entry.
  input  wire logic [smts_pkg::FLD_SEL_W-1:0] mem_wr_fld, // Write field.
  input  wire logic [smts_pkg::FIELD_W-1:0] mem_wr_data,  // Write data.
  input  wire logic [smts_pkg::IDX_W-1:0] mem_rd_idx,     // Read entry.
  output logic [smts_pkg::NUM_FIELDS*smts_pkg::FIELD_W-1:0]
               mem_rd_data,                               // Read entry data.
  output logic [NUM_GROUPS-1:0] grp_trig_start,           // Start pulses.
  output logic seq_busy,                                  // Group running.
  output logic [$clog2(NUM_GROUPS)-1:0] seq_grp,          // Running group.
  output logic [smts_pkg::IDX_W-1:0] seq_ptr,             // Buffer pointer.
  output logic link_valid,                                // Word offered.
  input  wire logic link_ready,                           // Word taken.
  output logic [smts_pkg::FIELD_W-1:0] link_tx_word,      // Transmit word.
  output logic [smts_pkg::FIELD_W-1:0] link_ctrl_word,    // Control word.
  output logic [smts_pkg::IDX_W-1:0] link_idx             // Entry index.
);

  localparam int GRP_W  = $clog2(NUM_GROUPS);
  localparam int WORD_W = smts_pkg::IDX_W + 2 * smts_pkg::FIELD_W;
  localparam int PTR_W  = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W  = $clog2(FIFO_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
  localparam logic [smts_pkg::TICK_W-1:0] TICK_LAST =
    smts_pkg::TICK_W'(TICK_CYCLES - 1);

  // Buffer memory state.
  logic [smts_pkg::FIELD_W-1:0] mem_r   [smts_pkg::NUM_ENTRIES]
                                        [smts_pkg::NUM_FIELDS];
  logic [smts_pkg::FIELD_W-1:0] mem_nxt [smts_pkg::NUM_ENTRIES]
                                        [smts_pkg::NUM_FIELDS];
  logic [smts_pkg::NUM_FIELDS*smts_pkg::FIELD_W-1:0] rd_nxt;

  // Entry fields.
  // Each entry holds transmit, receive, control and status words.
  always_comb begin
    mem_nxt = mem_r;
    if (mem_wr_en) begin
      mem_nxt[mem_wr_idx][mem_wr_fld] = mem_wr_data;
    end
    rd_nxt = {mem_r[mem_rd_idx][smts_pkg::FLD_STAT],
              mem_r[mem_rd_idx][smts_pkg::FLD_CTRL],
              mem_r[mem_rd_idx][smts_pkg::FLD_RX],
              mem_r[mem_rd_idx][smts_pkg::FLD_TX]};
  end

  // Registers the memory and the read port.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_r       <= '{default: '{default: '0}};
      mem_rd_data <= '0;
    end else begin
      mem_r       <= mem_nxt;
      mem_rd_data <= rd_nxt;
    end
  end

  // Trigger sources, synchronisers and the internal tick.
  logic [smts_pkg::EXT_NUM-1:0] ext_raw;
  logic [smts_pkg::EXT_NUM-1:0] ext_s1_r, ext_s2_r;
  logic [smts_pkg::NUM_SRC-1:0] src_lvl, src_prev_r;
  logic [smts_pkg::TICK_W-1:0]  tick_cnt_r, tick_cnt_nxt;
  logic                         tick_r, tick_nxt;

  // Pad-side pins.
  // Port pins arrive after the input buffer, so driven or external.
  assign ext_raw[smts_pkg::PORT_NUM-1:0] = port_a_pins;

  // Internal timer outputs.
  // Even timer channels from eight upward, ahead of the pad buffer.
  for (genvar t = 0; t < smts_pkg::TMR_NUM; t++) begin : g_tmr
    assign ext_raw[smts_pkg::PORT_NUM + t] =
      timer_coprocessor_channels[smts_pkg::TMR_CH_FIRST +
                                 smts_pkg::TMR_CH_STEP * t];
  end

  // Tick counter pulses once every TICK_CYCLES cycles.
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 1'b1;
    if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_nxt = '0;
      tick_nxt     = 1'b1;
    end
  end

  // Two-stage sync.
  // Only the second stage feeds the detectors below.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_s1_r   <= '0;
      ext_s2_r   <= '0;
      src_prev_r <= '0;
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      ext_s1_r   <= ext_raw;
      ext_s2_r   <= ext_s1_r;
      src_prev_r <= src_lvl;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // Source decode.
  // Code zero is a constant level; selection of it is also gated off.
  assign src_lvl = {tick_r, ext_s2_r, 1'b1};

  // Per-group trigger detection.
  logic [NUM_GROUPS-1:0] grp_hit, grp_take, pend_r, pend_nxt;

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    logic [smts_pkg::SEL_W-1:0] sel;
    logic                       lvl, prv, evt_ok;
    assign sel = group_trigger_select[g*smts_pkg::SEL_W +: smts_pkg::SEL_W];
    assign lvl = src_lvl[sel];
    assign prv = src_prev_r[sel];
    always_comb begin
      case (smts_pkg::smts_evt_e'(grp_trig_evt[g*2 +: 2]))
        smts_pkg::EVT_RISE: evt_ok = lvl & ~prv;
        smts_pkg::EVT_FALL: evt_ok = ~lvl & prv;
        smts_pkg::EVT_LOW:  evt_ok = ~lvl;
        smts_pkg::EVT_HIGH: evt_ok = lvl;
        default:            evt_ok = 1'b0;
      endcase
    end
    assign grp_hit[g] = grp_enable[g] & (sel != smts_pkg::SEL_NONE) &
                        evt_ok;
  end

  // Pending triggers: a new hit wins over the clear by a group start.
  assign pend_nxt = (pend_r & ~grp_take) | grp_hit;

  // Sequencer that walks the running group's entries.
  smts_pkg::smts_seq_e        state_r, state_nxt;
  logic [GRP_W-1:0]           grp_r, grp_nxt;
  logic [smts_pkg::IDX_W-1:0] ptr_r, ptr_nxt, end_r, end_nxt;
  logic [NUM_GROUPS-1:0]      start_nxt;
  logic                       push, fifo_in_ready;
  logic [WORD_W-1:0]          push_word;
  logic                       found;

  assign push      = (state_r == smts_pkg::SEQ_RUN) & fifo_in_ready;
  assign push_word = {ptr_r, mem_r[ptr_r][smts_pkg::FLD_CTRL],
                      mem_r[ptr_r][smts_pkg::FLD_TX]};

  // Group span walk.
  // Lowest pending group starts; entries run from start to end index.
  always_comb begin
    state_nxt = state_r;
    grp_nxt   = grp_r;
    ptr_nxt   = ptr_r;
    end_nxt   = end_r;
    grp_take  = '0;
    start_nxt = '0;
    found     = 1'b0;
    case (state_r)
      smts_pkg::SEQ_IDLE: begin
        for (int i = 0; i < NUM_GROUPS; i++) begin
          if (pend_r[i] && !found) begin
            found        = 1'b1;
            grp_take[i]  = 1'b1;
            start_nxt[i] = 1'b1;
            grp_nxt      = GRP_W'(i);
            ptr_nxt      = grp_start_idx[i*smts_pkg::IDX_W +:
                                         smts_pkg::IDX_W];
            end_nxt      = grp_end_idx[i*smts_pkg::IDX_W +:
                                       smts_pkg::IDX_W];
            state_nxt    = smts_pkg::SEQ_RUN;
          end
        end
      end
      smts_pkg::SEQ_RUN: begin
        if (push) begin
          ptr_nxt = ptr_r + 1'b1;
          if (ptr_r == end_r) begin
            state_nxt = smts_pkg::SEQ_IDLE;
          end
        end
      end
      default: state_nxt = smts_pkg::SEQ_IDLE;
    endcase
  end

  // Registers the sequencer and pending triggers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r        <= smts_pkg::SEQ_IDLE;
      grp_r          <= '0;
      ptr_r          <= '0;
      end_r          <= '0;
      pend_r         <= '0;
      grp_trig_start <= '0;
    end else begin
      state_r        <= state_nxt;
      grp_r          <= grp_nxt;
      ptr_r          <= ptr_nxt;
      end_r          <= end_nxt;
      pend_r         <= pend_nxt;
      grp_trig_start <= start_nxt;
    end
  end

  assign seq_busy = (state_r == smts_pkg::SEQ_RUN);
  assign seq_grp  = grp_r;
  assign seq_ptr  = ptr_r;

  // Word buffer between the sequencer and the clock crossing.
  logic [WORD_W-1:0] fifo_r [FIFO_DEPTH];
  logic [WORD_W-1:0] fifo_nxt [FIFO_DEPTH];
  logic [PTR_W-1:0]  wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              pop, fifo_out_valid;
  logic [WORD_W-1:0] hold_r, hold_nxt;
  logic              req_r, req_nxt, ack_s1_r, ack_s2_r, ack_r;

  assign fifo_in_ready  = (cnt_r != CNT_FULL);
  assign fifo_out_valid = (cnt_r != '0);
  assign pop            = fifo_out_valid & (ack_s2_r == req_r);

  // Pushes, pops and launches a word across when the last one is acked.
  always_comb begin
    fifo_nxt = fifo_r;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    cnt_nxt  = cnt_r;
    hold_nxt = hold_r;
    req_nxt  = req_r;
    if (push) begin
      fifo_nxt[wptr_r] = push_word;
      wptr_nxt = (wptr_r == PTR_LAST) ? '0 : wptr_r + 1'b1;
    end
    if (pop) begin
      hold_nxt = fifo_r[rptr_r];
      req_nxt  = ~req_r;
      rptr_nxt = (rptr_r == PTR_LAST) ? '0 : rptr_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Registers the buffer, the held word and the ack synchroniser.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fifo_r   <= '{default: '0};
      wptr_r   <= '0;
      rptr_r   <= '0;
      cnt_r    <= '0;
      hold_r   <= '0;
      req_r    <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      fifo_r   <= fifo_nxt;
      wptr_r   <= wptr_nxt;
      rptr_r   <= rptr_nxt;
      cnt_r    <= cnt_nxt;
      hold_r   <= hold_nxt;
      req_r    <= req_nxt;
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // Link-side state: reset and request synchronisers, output word.
  logic              lrst_s1_r, lrst_s2_r;
  logic              req_s1_r, req_s2_r, ack_nxt;
  logic              lvalid_r, lvalid_nxt;
  logic [WORD_W-1:0] ldata_r, ldata_nxt;

  // Captures the held word on a new request; acks once it is taken.
  always_comb begin
    lvalid_nxt = lvalid_r;
    ldata_nxt  = ldata_r;
    ack_nxt    = ack_r;
    if (lvalid_r && link_ready) begin
      lvalid_nxt = 1'b0;
      ack_nxt    = ~ack_r;
    end else if (!lvalid_r && (req_s2_r != ack_r)) begin
      lvalid_nxt = 1'b1;
      ldata_nxt  = hold_r;
    end
  end

  // Registers the link side on the link clock.
  always_ff @(posedge link_clk) begin
    lrst_s1_r <= rst_b;
    lrst_s2_r <= lrst_s1_r;
    if (!lrst_s2_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r    <= 1'b0;
      lvalid_r <= 1'b0;
      ldata_r  <= '0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      ack_r    <= ack_nxt;
      lvalid_r <= lvalid_nxt;
      ldata_r  <= ldata_nxt;
    end
  end

  assign link_valid     = lvalid_r;
  assign link_tx_word   = ldata_r[smts_pkg::FIELD_W-1:0];
  assign link_ctrl_word = ldata_r[2*smts_pkg::FIELD_W-1:smts_pkg::FIELD_W];
  assign link_idx       = ldata_r[WORD_W-1:2*smts_pkg::FIELD_W];

endmodule : smts_core

// ===== smts_core_sva.sv
// Concurrent checks on the start, sequencer, memory and link ports.
// Bound into every smts_core; the link check runs on the link clock.
`timescale 1ns/10ps
module smts_core_sva #(
  parameter int NUM_GROUPS  = 8, // Transfer groups.
  parameter int TICK_CYCLES = 4  // Tick period, cycles.
) (
  input wire logic                          clk,            // Clock.
  input wire logic                          rst_b,          // Reset, low.
  input wire logic                          link_clk,       // Link clock.
  input wire logic [NUM_GROUPS*7-1:0]       grp_start_idx,  // Firsts.
  input wire logic [NUM_GROUPS*7-1:0]       grp_end_idx,    // Lasts.
  input wire logic                          mem_wr_en,      // Write.
  input wire logic [6:0]                    mem_wr_idx,     // Entry.
  input wire logic [1:0]                    mem_wr_fld,     // Field.
  input wire logic [15:0]                   mem_wr_data,    // Data.
  input wire logic [6:0]                    mem_rd_idx,     // Read entry.
  input wire logic [63:0]                   mem_rd_data,    // Read data.
  input wire logic [NUM_GROUPS-1:0]         grp_trig_start, // Starts.
  input wire logic                          seq_busy,       // Running.
  input wire logic [$clog2(NUM_GROUPS)-1:0] seq_grp,        // Group.
  input wire logic [6:0]                    seq_ptr,        // Pointer.
  input wire logic                          link_valid,     // Offered.
  input wire logic                          link_ready,     // Taken.
  input wire logic [15:0]                   link_tx_word,   // Tx word.
  input wire logic [15:0]                   link_ctrl_word, // Ctrl word.
  input wire logic [6:0]                    link_idx        // Entry.
);
  start_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    |grp_trig_start |-> seq_busy && grp_trig_start[seq_grp])
    else $error("start without busy or group");
  start_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(grp_trig_start)) else $error("two groups started");
  start_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    |grp_trig_start |=> !(|grp_trig_start)) else $error("double start");
  start_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    |grp_trig_start |-> !$past(seq_busy)) else $error("start while busy");
  start_ptr_a: assert property (@(posedge clk) disable iff (!rst_b)
    |grp_trig_start |-> seq_ptr == grp_start_idx[seq_grp*7 +: 7])
    else $error("walk not at first entry");
  ptr_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    seq_busy && $past(seq_busy) |->
    seq_ptr == $past(seq_ptr) || seq_ptr == $past(seq_ptr) + 7'h1)
    else $error("pointer skipped");
  end_ptr_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(seq_busy) |-> $past(seq_ptr) == grp_end_idx[$past(seq_grp)*7 +: 7])
    else $error("walk not ended at last entry");
  mem_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_wr_en ##1 (!mem_wr_en && mem_rd_idx == $past(mem_wr_idx)) |=>
    mem_rd_data[$past(mem_wr_fld, 2)*16 +: 16] == $past(mem_wr_data, 2))
    else $error("written field not read back");
  link_hold_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    link_valid && !link_ready |=> link_valid && $stable(link_tx_word) &&
    $stable(link_ctrl_word) && $stable(link_idx)) else $error("word dropped");
endmodule : smts_core_sva

bind smts_core smts_core_sva #(.NUM_GROUPS(NUM_GROUPS),
  .TICK_CYCLES(TICK_CYCLES)) u_smts_core_sva (.*);

// ===== smts_link_sink.sv
// Link consumer model: takes words offered by the block on the link clock.
// Assumes the bench raises slow to make it stall on a pseudo-random pattern.
`timescale 1ns/10ps
module smts_link_sink (
  input  wire logic link_clk,  // Link clock.
  input  wire logic slow,      // Stall now and then.
  output logic      link_ready // Word taken.
);
  logic [7:0] lf_r = 8'h5a;
  initial link_ready = 1'b0;
  // Step the pattern and set ready just after each link edge.
  always @(posedge link_clk) begin
    lf_r <= {lf_r[6:0], lf_r[7] ^ lf_r[5] ^ lf_r[4] ^ lf_r[3]};
    link_ready <= #1 !slow || lf_r[0];
  end
endmodule : smts_link_sink

// ===== testbench.sv
// Self-checking bench for the trigger and buffer memory block.
// Drives pins, group set-up and memory; a sink model takes link words.
`timescale 1ns/10ps
module testbench;
  logic clk = 0, link_clk = 0, rst_b = 0, slow = 0, mem_wr_en = 0;
  logic [7:0] port_a_pins = '0, en = '1, gs;
  logic [18:0] tmr = '0;
  logic [31:0] sel = '0, seed = 32'h2aba;
  logic [15:0] evt = '0, wd = '0, lt, lc;
  logic [55:0] st, ed;
  logic [6:0] wi = '0, ri = '0, li;
  logic [1:0] wf = '0;
  logic [63:0] rd, mdl [128];
  logic link_valid, link_ready;
  logic [38:0] got [$];
  int miscompares = 0, checked = 0, cyc = 0, nst = 0;

  smts_core #(.TICK_CYCLES(4)) u_smts_core (
    .clk, .rst_b, .link_clk, .port_a_pins, .link_ready, .link_valid,
    .timer_coprocessor_channels(tmr), .grp_enable(en),
    .group_trigger_select(sel), .grp_trig_evt(evt), .grp_start_idx(st),
    .grp_end_idx(ed), .mem_wr_en, .mem_wr_idx(wi), .mem_wr_fld(wf),
    .mem_wr_data(wd), .mem_rd_idx(ri), .mem_rd_data(rd),
    .grp_trig_start(gs), .seq_busy(), .seq_grp(), .seq_ptr(),
    .link_tx_word(lt), .link_ctrl_word(lc), .link_idx(li));
  smts_link_sink u_smts_link_sink (.link_clk, .slow, .link_ready);

  // Clocks: 25 ns interface clock, 30 ns link clock offset in phase.
  initial forever #12.5 clk = ~clk;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  // Collect every word the sink takes, and count starts and cycles.
  always @(posedge link_clk) if (link_valid && link_ready)
    got.push_back({li, lc, lt});
  always @(posedge clk) begin
    nst = nst + (gs !== '0);
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(logic [63:0] s, logic [63:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic fire(int c, logic v);
    if (c <= 8) port_a_pins[c-1] = v;
    else tmr[8+2*(c-9)] = v;
  endtask : fire
  // Wait for one start, then compare the group's words in walk order.
  task automatic walk(int g);
    int s = st[g*7 +: 7];
    int k = (ed[g*7 +: 7] - s) & 127;
    int n = 0;
    while (gs === '0 && n < 300) begin
      step();
      n++;
    end
    check(gs, 8'h1 << g);
    while (got.size() <= k && n < 3000) begin
      step();
      n++;
    end
    for (int i = 0; i <= k; i++) begin
      int j = (s + i) & 127;
      check(got.pop_front(), {j[6:0], mdl[j][47:32], mdl[j][15:0]});
    end
  endtask : walk
  task automatic final_report();
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    for (int g = 0; g < 8; g++) begin
      st[g*7 +: 7] = (g == 7) ? 7'h7e : 7'(g * 16);
      ed[g*7 +: 7] = (g == 7) ? 7'h01 : 7'(g * 16 + 2);
    end
    step(8);
    rst_b = 1;
    // Fill every field of every entry, then read all back.
    for (int i = 0; i < 512; i++) begin
      seed = xs(seed);
      mem_wr_en = 1;
      {wi, wf} = 9'(i);
      wd = seed[15:0];
      mdl[wi][wf*16 +: 16] = wd;
      step();
    end
    mem_wr_en = 0;
    for (int i = 127; i >= 0; i--) begin
      ri = 7'(i);
      step();
      check(rd, mdl[i]);
    end
    // Each source code starts its group on a rising edge.
    for (int c = 1; c < 16; c++) begin
      slow = c[0];
      sel = 32'(c) << (4 * (c % 8));
      step(4);
      if (c < 15) fire(c, 1);
      walk(c % 8);
      if (c < 15) begin
        fire(c, 0);
        step(60);
        check(got.size(), 0);
      end
      sel = '0;
      step(100);
      got.delete();
    end
    // A disabled group ignores its source, and group 0 on code zero with
    // a high-level event must never start either.
    en = 8'hfd;
    sel = 32'h10;
    evt = 16'h3;
    step(100);
    nst = 0;
    fire(1, 1);
    step(40);
    check(nst, 0);
    fire(1, 0);
    en = '1;
    evt = '0;
    port_a_pins[2] = 1;
    slow = 0;
    step(4);
    // The pin settles high before the low-level group is armed.
    sel = 32'h3 << 8;
    evt = 16'h2 << 4;
    step(10);
    // A held low level keeps restarting its group.
    nst = 0;
    port_a_pins[2] = 0;
    step(150);
    check(nst >= 2, 1);
    port_a_pins[2] = 1;
    step(100);
    // A falling edge starts its group exactly once.
    got.delete();
    port_a_pins[3] = 1;
    step(4);
    sel = 32'h4 << 12;
    evt = 16'h1 << 6;
    step(4);
    port_a_pins[3] = 0;
    walk(3);
    step(60);
    check(got.size(), 0);
    // A held high level keeps restarting its group.
    nst = 0;
    evt = 16'h3 << 6;
    port_a_pins[3] = 1;
    step(150);
    check(nst >= 2, 1);
    port_a_pins[3] = 0;
    step(100);
    final_report();
  end
endmodule : testbench
